// *** hecl_eeprom_model.sv ***
/*
 Partner model: double-byte-addressed SPI serial EEPROM holding one image.
 Assumes mode 0 frames from the loader and an image set before each select.
*/
`timescale 1ns/100ps
module hecl_eeprom_model (
    input  wire logic         spi_sck,
    input  wire logic         spi_cs_n,
    input  wire logic         spi_mosi,
    input  wire logic [103:0] image,
    output logic              spi_miso,
    output logic [23:0]       header
);
    int bit_cnt;
    initial spi_miso = 1'b0;
    always @(negedge spi_cs_n) begin
        bit_cnt = 0;
    end
    // Command byte and two address bytes come before any data
    always @(posedge spi_sck) begin
        if (!spi_cs_n && bit_cnt < 24) header <= {header[22:0], spi_mosi};
        if (!spi_cs_n) bit_cnt <= bit_cnt + 1;
    end
    // Undriven phases toggle so a stale level never passes for data
    always @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n || bit_cnt < 24 || bit_cnt > 127) spi_miso <= ~spi_miso;
        else spi_miso <= image[8 * ((bit_cnt - 24) / 8) + 7 - (bit_cnt - 24) % 8];
    end
endmodule : hecl_eeprom_model

// *** hecl_loader.sv ***
/*
 Hub start-up configuration loader: SPI EEPROM reader, image decoder,
 descriptor-type gate and AHB-Lite register slave.
 Assumes a double-byte-addressed SPI EEPROM in mode 0 and one AHB-Lite master.
*/
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
module hecl_loader (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic                       spi_sck,
    output logic                       spi_cs_n,
    output logic                       spi_mosi,
    input  wire logic                  spi_miso,
    input  wire logic                  desc_req_valid,
    input  wire logic [7:0]            desc_type,
    output logic                       desc_accept,
    output logic                       desc_stall,
    output logic                       attach_enable,
    output hecl_pkg::hecl_cfg_type     cfg
);
    // ==========================================
    // State
    // ==========================================
    hecl_pkg::hecl_state_type state;
    hecl_pkg::hecl_kind_type  kind;
    logic [7:0]  img [0:hecl_pkg::IMG_BYTES-1];
    logic        miso_s1;
    logic        miso_s2;
    logic [3:0]  div_cnt;
    logic [6:0]  bit_cnt;
    logic [23:0] tx_sh;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_byte;
    logic [3:0]  byte_idx;
    logic        tick;
    logic        reload;
    logic        ph_write;
    logic [7:0]  ph_addr;
    logic        addr_ok;
    logic [31:0] next_rdata;
    hecl_pkg::hecl_cfg_type next_cfg;

    assign tick     = (div_cnt == 4'(hecl_pkg::SCK_HALF_CYC - 1));
    assign rx_byte  = {rx_sh[6:0], miso_s2};
    assign byte_idx = bit_cnt[6:3] - hecl_pkg::FIRST_DATA_HI;

    // ==========================================
    // MISO synchroniser
    // ==========================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            miso_s1 <= spi_miso;
            miso_s2 <= miso_s1;
        end
    end

    // ==========================================
    // Load sequencer
    // ==========================================
    // Command, two address bytes, then 13 data bytes in one frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state    <= hecl_pkg::ST_START;
            div_cnt  <= 4'h0;
            bit_cnt  <= 7'h00;
            tx_sh    <= 24'h000000;
            rx_sh    <= 8'h00;
            spi_sck  <= 1'b0;
            spi_cs_n <= 1'b1;
            spi_mosi <= 1'b0;
        end else begin
            unique case (state)
                hecl_pkg::ST_START: begin
                    tx_sh    <= {hecl_pkg::SPI_READ_CMD[6:0], hecl_pkg::IMG_BASE, 1'b0};
                    spi_mosi <= hecl_pkg::SPI_READ_CMD[7];
                    spi_cs_n <= 1'b0;
                    spi_sck  <= 1'b0;
                    bit_cnt  <= 7'h00;
                    div_cnt  <= 4'h0;
                    state    <= hecl_pkg::ST_SHIFT;
                end
                hecl_pkg::ST_SHIFT: begin
                    div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
                    if (tick && !spi_sck) begin
                        spi_sck <= 1'b1;
                        rx_sh   <= rx_byte;
                    end else if (tick) begin
                        spi_sck  <= 1'b0;
                        spi_mosi <= tx_sh[23];
                        tx_sh    <= {tx_sh[22:0], 1'b0};
                        bit_cnt  <= bit_cnt + 7'h01;
                        if (bit_cnt == hecl_pkg::LAST_BIT) begin
                            spi_cs_n <= 1'b1;
                            state    <= hecl_pkg::ST_DECODE;
                        end
                    end
                end
                hecl_pkg::ST_DECODE: state <= hecl_pkg::ST_DONE;
                hecl_pkg::ST_DONE: begin
                    if (reload) begin
                        state <= hecl_pkg::ST_START;
                    end
                end
                default: state <= hecl_pkg::ST_START;
            endcase
        end
    end

    // Image capture on each rising SCK that ends a data byte, after the command and address
    always_ff @(posedge hclk) begin
        if (state == hecl_pkg::ST_SHIFT && tick && !spi_sck
            && bit_cnt >= hecl_pkg::CMD_BITS && bit_cnt[2:0] == 3'h7) begin
            img[byte_idx] <= rx_byte;
        end
    end

    // ==========================================
    // Decode
    // ==========================================
    always_comb begin
        logic [7:0] f;
        f = img[12];
        next_cfg = cfg;
        next_cfg.vendor_id              = hecl_pkg::DEF_VENDOR;
        next_cfg.product_id             = hecl_pkg::DEF_PRODUCT;
        next_cfg.device_release_word    = hecl_pkg::DEF_RELEASE;
        {next_cfg.enabled_port_fault_filter_ms,
         next_cfg.disabled_port_fault_filter_ms} = hecl_pkg::DEF_FILTER;
        {next_cfg.usable_port_mask,
         next_cfg.detachable_port_mask} = hecl_pkg::DEF_PORTS;
        next_cfg.upstream_current_units = hecl_pkg::DEF_UPSTREAM;
        next_cfg.controller_current_ma  = hecl_pkg::DEF_CTRL_MA;
        next_cfg.power_good_delay_units = hecl_pkg::DEF_PWR_GOOD;
        next_cfg.accept_zero_descriptor_type = 1'b0;
        next_cfg.restrict_to_12mbit     = 1'b0;
        next_cfg.indicator_leds_off     = 1'b0;
        next_cfg.shared_power_switching = 1'b0;
        next_cfg.one_translator_mode    = 1'b0;
        next_cfg.suppress_frame_end_eop = 1'b0;
        // Unknown code leaves every default in place
        if (img[0] == hecl_pkg::CODE_FULL || img[0] == hecl_pkg::CODE_ID_ONLY) begin
            next_cfg.vendor_id           = {img[2], img[1]};
            next_cfg.product_id          = {img[4], img[3]};
            next_cfg.device_release_word = {img[6], img[5]};
        end
        if (img[0] == hecl_pkg::CODE_FULL) begin
            {next_cfg.enabled_port_fault_filter_ms,
             next_cfg.disabled_port_fault_filter_ms} = img[7];
            {next_cfg.usable_port_mask,
             next_cfg.detachable_port_mask} = img[8];
            next_cfg.upstream_current_units = img[9];
            next_cfg.controller_current_ma  = img[10];
            next_cfg.power_good_delay_units = img[11];
            // Bits 6 and 3 are never looked at
            next_cfg.accept_zero_descriptor_type = f[hecl_pkg::B_ZERO_DESC];
            next_cfg.restrict_to_12mbit     = f[hecl_pkg::B_12MBIT];
            next_cfg.indicator_leds_off     = f[hecl_pkg::B_LEDS_OFF];
            next_cfg.shared_power_switching = f[hecl_pkg::B_SHARED];
            next_cfg.one_translator_mode    = f[hecl_pkg::B_ONE_TT];
            next_cfg.suppress_frame_end_eop = f[hecl_pkg::B_NO_EOP];
        end
        next_cfg.port_count = 3'h0;
        for (int i = 0; i < 4; i++) begin
            next_cfg.port_count = next_cfg.port_count
                                  + {2'h0, next_cfg.usable_port_mask[i]};
        end
        next_cfg.removable_field = {3'h0, next_cfg.detachable_port_mask, 1'b0};
        next_cfg.hub_characteristics = hecl_pkg::DEF_HUB_CHAR;
        if (next_cfg.shared_power_switching) begin
            next_cfg.hub_characteristics[4:3] = 2'h0;
            next_cfg.hub_characteristics[1:0] = 2'h0;
        end
        if (next_cfg.indicator_leds_off) begin
            next_cfg.hub_characteristics[7] = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg      <= '0;
            kind     <= hecl_pkg::KIND_NONE;
        end else if (state == hecl_pkg::ST_DECODE) begin
            cfg  <= next_cfg;
            kind <= (img[0] == hecl_pkg::CODE_FULL)    ? hecl_pkg::KIND_FULL :
                    (img[0] == hecl_pkg::CODE_ID_ONLY) ? hecl_pkg::KIND_ID :
                                                         hecl_pkg::KIND_NONE;
        end
    end

    // ==========================================
    // Attach and descriptor gate
    // ==========================================
    // Requests during loading go unanswered; one in the reload cycle is still answered from the old cfg
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            attach_enable <= 1'b0;
            desc_accept   <= 1'b0;
            desc_stall    <= 1'b0;
        end else begin
            attach_enable <= (state == hecl_pkg::ST_DONE) && !reload;
            desc_accept   <= 1'b0;
            desc_stall    <= 1'b0;
            if (desc_req_valid && state == hecl_pkg::ST_DONE) begin
                if (desc_type == hecl_pkg::HUB_DESC_TYPE
                    || (desc_type == hecl_pkg::ZERO_DESC
                        && cfg.accept_zero_descriptor_type)) begin
                    desc_accept <= 1'b1;
                end else begin
                    desc_stall  <= 1'b1;
                end
            end
        end
    end

    // ==========================================
    // AHB-Lite slave, zero wait states
    // ==========================================
    assign addr_ok = hsel && hready && htrans[1] && (haddr[31:8] == 24'h0);
    assign reload  = ph_write && (ph_addr == hecl_pkg::A_CONTROL) && hwdata[0];

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr[7:0])
            hecl_pkg::A_STATUS:  next_rdata = {26'h0, state == hecl_pkg::ST_DONE,
                                               attach_enable, kind, 1'b0,
                                               state == hecl_pkg::ST_DONE};
            hecl_pkg::A_IDENT:   next_rdata = {cfg.product_id, cfg.vendor_id};
            hecl_pkg::A_RELEASE: next_rdata = {16'h0, cfg.device_release_word};
            hecl_pkg::A_POWER:   next_rdata = {cfg.power_good_delay_units,
                                               cfg.controller_current_ma,
                                               cfg.upstream_current_units,
                                               cfg.enabled_port_fault_filter_ms,
                                               cfg.disabled_port_fault_filter_ms};
            hecl_pkg::A_PORTS:   next_rdata = {cfg.hub_characteristics, 5'h0,
                                               cfg.port_count, cfg.usable_port_mask,
                                               cfg.detachable_port_mask};
            hecl_pkg::A_FLAGS:   next_rdata = {26'h0,
                                               cfg.accept_zero_descriptor_type,
                                               cfg.restrict_to_12mbit,
                                               cfg.indicator_leds_off,
                                               cfg.shared_power_switching,
                                               cfg.one_translator_mode,
                                               cfg.suppress_frame_end_eop};
            default:             next_rdata = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h0) begin
            next_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_write  <= 1'b0;
            ph_addr   <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            ph_write  <= addr_ok && hwrite;
            ph_addr   <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    // ==========================================
    // Checks
    // ==========================================
    chk_full_ident: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hecl_pkg::ST_DECODE && img[0] == hecl_pkg::CODE_FULL
        |=> cfg.vendor_id == {$past(img[2]), $past(img[1])})
        else $error("vendor word not assembled low byte first");
    chk_port_count: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hecl_pkg::ST_DONE |-> cfg.port_count == $countones(cfg.usable_port_mask))
        else $error("port count differs from usable mask");
    chk_id_defaults: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hecl_pkg::ST_DECODE && img[0] == hecl_pkg::CODE_ID_ONLY
        |=> cfg.power_good_delay_units == hecl_pkg::DEF_PWR_GOOD
            && cfg.usable_port_mask == 4'hF && !cfg.restrict_to_12mbit)
        else $error("identity-only load changed a default");
    chk_bad_code: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hecl_pkg::ST_DECODE && img[0] != hecl_pkg::CODE_FULL
        && img[0] != hecl_pkg::CODE_ID_ONLY
        |=> cfg.vendor_id == hecl_pkg::DEF_VENDOR && kind == hecl_pkg::KIND_NONE)
        else $error("unknown image was not ignored");
    chk_zero_desc: assert property (@(posedge hclk) disable iff (!hresetn)
        desc_req_valid && state == hecl_pkg::ST_DONE && desc_type == 8'h00
        |=> desc_accept == $past(cfg.accept_zero_descriptor_type)
            && desc_stall == !$past(cfg.accept_zero_descriptor_type))
        else $error("zero descriptor type answered wrongly");
    chk_no_early: assert property (@(posedge hclk) disable iff (!hresetn)
        state != hecl_pkg::ST_DONE |=> !attach_enable && !desc_accept && !desc_stall)
        else $error("attach or answer before load finished");
    chk_gang_chars: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hecl_pkg::ST_DONE |-> (cfg.shared_power_switching
            ? cfg.hub_characteristics[4:0] == 5'h00 : cfg.hub_characteristics[4:0] == 5'h09))
        else $error("power switching mode not in characteristics");
    chk_led_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hecl_pkg::ST_DONE |-> cfg.hub_characteristics[7] == !cfg.indicator_leds_off)
        else $error("indicator bit disagrees with leds off flag");
    chk_frame_len: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(spi_cs_n) |-> !spi_cs_n [*8] ##1 (!spi_cs_n)[*8])
        else $error("read frame ended too early");
    chk_flag_copy: assert property (@(posedge hclk) disable iff (!hresetn)
        state == hecl_pkg::ST_DECODE && img[0] == hecl_pkg::CODE_FULL
        |=> cfg.suppress_frame_end_eop == $past(img[12][0])
            && cfg.restrict_to_12mbit == $past(img[12][5]))
        else $error("byte 12 flags not copied");
endmodule : hecl_loader

// *** hecl_loader_tb_top.sv ***
/*
 Bench of the hub start-up loader: four image loads, registers, descriptor gate.
 Assumes the EEPROM model beside it and a zero-wait AHB-Lite slave.
*/
`timescale 1ns/100ps
module hecl_loader_tb_top;
    // ==========================================
    // Signals and images
    // ==========================================
    // Reserved bit 3 of byte 12 stays clear in every image
    localparam logic [103:0] IMG_A = 104'hB5193C7B965A0210C3D4A1B2D2;
    localparam logic [103:0] IMG_B = 104'h420100FF0FF055AA1234FE01D2;
    logic                   hclk, hresetn, hsel, hwrite, spi_miso, desc_req_valid;
    logic [31:0]            haddr, hwdata, hrdata, rd;
    logic [1:0]             htrans;
    logic [2:0]             hsize;
    logic [7:0]             desc_type;
    logic                   hreadyout, hresp, spi_sck, spi_cs_n, spi_mosi;
    logic                   desc_accept, desc_stall, attach_enable;
    logic [103:0]           image;
    logic [23:0]            header;
    hecl_pkg::hecl_cfg_type cfg, ex;
    int                     err_count, total_checks;
    wire                    hready = hreadyout;
    hecl_loader uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso, .desc_req_valid,
        .desc_type, .desc_accept, .desc_stall, .attach_enable, .cfg);
    hecl_eeprom_model eeprom (.spi_sck, .spi_cs_n, .spi_mosi, .image, .spi_miso, .header);
    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic compare(input string what, input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : compare
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        compare("response", hresp, 1'b0);
    endtask : ahb
    // Byte 0 sits in the low byte of an image
    function automatic hecl_pkg::hecl_cfg_type expect_cfg(input logic [103:0] im);
        logic [7:0] b [13];
        for (int i = 0; i < 13; i++) b[i] = im[8*i +: 8];
        if (b[0] != 8'hD2) {b[12], b[11], b[10], b[9], b[8], b[7]} = 48'h003264_32FF88;
        if (b[0] != 8'hD2 && b[0] != 8'hD0) {b[6], b[5], b[4], b[3], b[2], b[1]} =
            {hecl_pkg::DEF_RELEASE, hecl_pkg::DEF_PRODUCT, hecl_pkg::DEF_VENDOR};
        expect_cfg = '0;
        expect_cfg[120:73] = {b[2], b[1], b[4], b[3], b[6], b[5]};
        expect_cfg[72:57] = {b[7], b[8]};
        expect_cfg.port_count = 3'($countones(b[8][7:4]));
        expect_cfg[53:30] = {b[9], b[10], b[11]};
        expect_cfg.hub_characteristics = {8'h00, ~b[12][4], 3'h0, ~b[12][2], 2'h0, ~b[12][2]};
        expect_cfg.removable_field = {3'h0, b[8][3:0], 1'b0};
        expect_cfg[5:0] = {b[12][7], b[12][5:4], b[12][2:0]};
    endfunction : expect_cfg
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic run_image(input logic restart, input logic [103:0] im, input logic [1:0] kind);
        int   n;
        logic early;
        image <= im;
        ex = expect_cfg(im);
        if (restart) ahb(1'b1, hecl_pkg::A_CONTROL, 32'h1);
        repeat (2) @(posedge hclk);
        desc_type <= hecl_pkg::HUB_DESC_TYPE;
        desc_req_valid <= 1'b1;
        early = 1'b0;
        repeat (50) begin
            @(posedge hclk);
            early = early | desc_accept | desc_stall | attach_enable;
        end
        desc_req_valid <= 1'b0;
        compare("answer while loading", early, 1'b0);
        n = 0;
        while (attach_enable !== 1'b1 && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        compare("load finished", n < 3000, 1'b1);
        compare("read header", header, {hecl_pkg::SPI_READ_CMD, hecl_pkg::IMG_BASE});
        compare("identity", cfg[120:73], ex[120:73]);
        compare("fault filters", cfg[72:65], ex[72:65]);
        compare("port masks", cfg[64:54], ex[64:54]);
        compare("removable field", cfg[13:6], ex[13:6]);
        compare("power figures", cfg[53:30], ex[53:30]);
        compare("hub characteristics", cfg[29:14], ex[29:14]);
        compare("option flags", cfg[5:0], ex[5:0]);
        ahb(1'b0, hecl_pkg::A_STATUS, 32'h0);
        compare("status", rd, {26'h0, 2'b11, kind, 2'b01});
        ahb(1'b0, hecl_pkg::A_PORTS, 32'h0);
        compare("ports register", rd, {ex[29:14], 5'h0, ex[56:54], ex[64:57]});
        ahb(1'b0, hecl_pkg::A_IDENT, 32'h0);
        compare("identity register", rd, {ex[104:89], ex[120:105]});
        ahb(1'b0, hecl_pkg::A_RELEASE, 32'h0);
        compare("release register", rd, {16'h0, ex[88:73]});
        ahb(1'b0, hecl_pkg::A_POWER, 32'h0);
        compare("power", rd, {ex[37:30], ex[45:38], ex[53:46], ex[72:65]});
        ahb(1'b0, hecl_pkg::A_FLAGS, 32'h0);
        compare("flags register", rd, {26'h0, ex[5:0]});
    endtask : run_image
    task automatic desc_try(input logic [7:0] t, input logic [1:0] exp);
        desc_type <= t;
        desc_req_valid <= 1'b1;
        @(posedge hclk);
        desc_req_valid <= 1'b0;
        @(posedge hclk);
        compare("descriptor answer", {desc_accept, desc_stall}, exp);
    endtask : desc_try
    // ==========================================
    // Clock, watchdog and main sequence
    // ==========================================
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // Four loads take about 4200 cycles; the limit leaves ample slack
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, desc_req_valid, desc_type} = '0;
        hsize = 3'h2;
        image = IMG_A;
        err_count = 0;
        total_checks = 0;
        hresetn = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        run_image(1'b0, IMG_A, 2'h2);
        desc_try(8'h29, 2'b10);
        desc_try(8'h00, 2'b10);
        desc_try(8'h06, 2'b01);
        ahb(1'b0, 8'h40, 32'h0);
        compare("unmapped read", rd, 32'h0);
        ahb(1'b1, hecl_pkg::A_STATUS, 32'h0);
        ahb(1'b0, hecl_pkg::A_STATUS, 32'h0);
        compare("status after write", rd, 32'h39);
        run_image(1'b1, IMG_B, 2'h2);
        desc_try(8'h00, 2'b01);
        desc_try(8'h29, 2'b10);
        run_image(1'b1, {IMG_A[103:8], 8'hD0}, 2'h1);
        run_image(1'b1, {IMG_A[103:8], 8'hD1}, 2'h0);
        stop_test();
    end
endmodule : hecl_loader_tb_top

// *** hecl_pkg.sv ***
/*
 Constants, register map and carrier types of the hub start-up configuration loader.
 Assumes a 125 MHz hclk and a double-byte-addressed SPI serial EEPROM.
*/
package hecl_pkg;
    // ==========================================
    // Image layout and load codes
    // ==========================================
    localparam logic [7:0] CODE_FULL     = 8'hD2;
    localparam logic [7:0] CODE_ID_ONLY  = 8'hD0;
    localparam int         IMG_BYTES     = 13;
    localparam logic [7:0] SPI_READ_CMD  = 8'h03;
    localparam logic [15:0] IMG_BASE     = 16'h0000;
    localparam logic [6:0] CMD_BITS      = 7'h18;
    localparam logic [6:0] LAST_BIT      = 7'h7F;
    localparam logic [3:0] FIRST_DATA_HI = 4'h3;
    // Identity defaults: arbitrary values
    localparam logic [15:0] DEF_VENDOR   = 16'h1234;
    localparam logic [15:0] DEF_PRODUCT  = 16'h5678;
    localparam logic [15:0] DEF_RELEASE  = 16'h0100;
    // Built-in defaults of the configured fields
    localparam logic [7:0] DEF_FILTER    = 8'h88;
    localparam logic [7:0] DEF_PORTS     = 8'hFF;
    localparam logic [7:0] DEF_UPSTREAM  = 8'h32;
    localparam logic [7:0] DEF_CTRL_MA   = 8'h64;
    localparam logic [7:0] DEF_PWR_GOOD  = 8'h32;
    localparam logic [15:0] DEF_HUB_CHAR = 16'h0089;
    localparam logic [2:0] DEF_PORT_CNT  = 3'h4;
    localparam logic [7:0] HUB_DESC_TYPE = 8'h29;
    localparam logic [7:0] ZERO_DESC     = 8'h00;
    // Flag positions in byte 12
    localparam int B_ZERO_DESC = 7;
    localparam int B_12MBIT    = 5;
    localparam int B_LEDS_OFF  = 4;
    localparam int B_SHARED    = 2;
    localparam int B_ONE_TT    = 1;
    localparam int B_NO_EOP    = 0;
    // ==========================================
    // Timing
    // ==========================================
    localparam int CLK_PS         = 8000;
    localparam int SCK_HALF_PS    = 32000;
    localparam int SCK_HALF_CYC   = (SCK_HALF_PS + CLK_PS - 1) / CLK_PS;
    // ==========================================
    // Register map (byte addresses)
    // ==========================================
    localparam logic [7:0] A_STATUS  = 8'h00;
    localparam logic [7:0] A_IDENT   = 8'h04;
    localparam logic [7:0] A_RELEASE = 8'h08;
    localparam logic [7:0] A_POWER   = 8'h0C;
    localparam logic [7:0] A_PORTS   = 8'h10;
    localparam logic [7:0] A_FLAGS   = 8'h14;
    localparam logic [7:0] A_CONTROL = 8'h18;
    // ==========================================
    // Types
    // ==========================================
    typedef enum logic [1:0] {
        KIND_NONE = 2'h0, KIND_ID = 2'h1, KIND_FULL = 2'h2
    } hecl_kind_type;
    typedef enum logic [3:0] {
        ST_START  = 4'h1,
        ST_SHIFT  = 4'h2,
        ST_DECODE = 4'h4,
        ST_DONE   = 4'h8
    } hecl_state_type;
    typedef struct packed {
        logic [15:0] vendor_id;
        logic [15:0] product_id;
        logic [15:0] device_release_word;
        logic [3:0]  enabled_port_fault_filter_ms;
        logic [3:0]  disabled_port_fault_filter_ms;
        logic [3:0]  usable_port_mask;
        logic [3:0]  detachable_port_mask;
        logic [2:0]  port_count;
        logic [7:0]  upstream_current_units;
        logic [7:0]  controller_current_ma;
        logic [7:0]  power_good_delay_units;
        logic [15:0] hub_characteristics;
        logic [7:0]  removable_field;
        logic        accept_zero_descriptor_type;
        logic        restrict_to_12mbit;
        logic        indicator_leds_off;
        logic        shared_power_switching;
        logic        one_translator_mode;
        logic        suppress_frame_end_eop;
    } hecl_cfg_type;
endpackage : hecl_pkg
